// *** dv/bank_checker_assertions.sv ***
`default_nettype none
// pin-level bank checks
module bank_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // bus and inputs
   input wire logic        sda_oe,
   input wire logic        overtemp_trip,
   input wire logic [15:0] aux_sense_level,
   // setpoints
   input wire logic [7:0]  output_trim_offset,
   input wire logic [4:0]  load_line_code,
   input wire logic [4:0]  current_limit_code,
   input wire logic [29:0] phase_balance_code,
   // status
   input wire logic        regulator_hot_indicator,
   input wire logic        aux_high_flag,
   input wire logic        aux_low_flag,
   input wire logic        aux_fault,
   input wire logic        alert_n
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // setpoints move only while acking
   a_trim_commit: assert property (!$stable(output_trim_offset) |-> sda_oe)
      else $error("trim moved off ack");
   a_load_commit: assert property (!$stable(load_line_code) |-> sda_oe)
      else $error("load line moved off ack");
   a_gain_commit: assert property (!$stable(phase_balance_code) |-> sda_oe)
      else $error("gain moved off ack");
   a_reset_values: assert property ($rose(nrst) |-> load_line_code == 5'h10
      && current_limit_code == 5'h10 && output_trim_offset == 8'h00) else $error("bad default");
   a_hot_set: assert property (overtemp_trip |=> regulator_hot_indicator)
      else $error("hot not set");
   a_hot_clear: assert property ($fell(regulator_hot_indicator) |-> !$past(overtemp_trip))
      else $error("hot cleared under trip");
   a_alert_cause: assert property (!alert_n |-> aux_high_flag || aux_low_flag)
      else $error("alert without aux flag");
   // zero never exceeds a limit
   a_aux_zero: assert property ((aux_sense_level == 16'h0000) [*3]
      |-> !aux_high_flag && !aux_fault) else $error("flag on zero aux");
   c_alert: cover property (!alert_n);
   c_hot_drop: cover property ($fell(regulator_hot_indicator));
   c_ack: cover property ($rose(sda_oe));
endmodule
bind regulator_setpoint_command_bank bank_checker u_chk (.*);
`default_nettype wire

// *** dv/bus_host.sv ***
`default_nettype none
// two-wire host, clock idles high
module bus_host #(
   parameter logic [6:0] ADDR = 7'h40
) (
   input wire logic    sda_oe,
   output logic        scl,
   output logic        sda,
   output logic [15:0] rd_data,
   output logic        rd_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pull = 1'b0;  // host pulls data low
   logic a;            // ack slot level
   assign sda = !(pull | sda_oe);  // released line reads high
   initial begin
      scl = 1'b1;
      rd_strobe = 1'b0;
      rd_data = '0;
   end
   // set while low, sampled high
   task automatic bit_io(input logic b, output logic r);
      pull = !b;
      #40 scl = 1'b1;
      #40 r = sda;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic start();
      pull = 1'b0;
      #40 scl = 1'b1;
      #40 pull = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic stop();
      pull = 1'b1;
      #40 scl = 1'b1;
      #40 pull = 1'b0;
      #40;
   endtask
   // byte msb first, then the ack slot
   task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(k, a);
   endtask
   // low byte, then high if wide
   task automatic wr(input logic [7:0] c, input logic [15:0] v, input logic w);
      logic [7:0] q;
      start();
      xfer({ADDR, 1'b0}, 1'b1, q);
      xfer(c, 1'b1, q);
      xfer(v[7:0], 1'b1, q);
      if (w) xfer(v[15:8], 1'b1, q);
      stop();
   endtask
   // ack low byte only if wide
   task automatic rd(input logic [7:0] c, input logic w);
      logic [7:0] lo;
      logic [7:0] hi;
      hi = 8'h00;
      start();
      xfer({ADDR, 1'b0}, 1'b1, lo);
      xfer(c, 1'b1, lo);
      start();
      xfer({ADDR, 1'b1}, 1'b1, lo);
      xfer(8'hFF, !w, lo);
      if (w) xfer(8'hFF, 1'b1, hi);
      stop();
      rd_data = {hi, lo};
      rd_strobe = 1'b1;
      rd_strobe <= #1 1'b0;
   endtask
endmodule
`default_nettype wire

// *** dv/regulator_setpoint_command_bank_bench.sv ***
`default_nettype none
// defaults, write-back, status
module regulator_setpoint_command_bank_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic              clk;
   logic              nrst;
   logic              scl;
   logic              sda;
   logic              sda_oe;
   logic [15:0]       aux;
   logic [15:0]       mon;
   logic [15:0]       temp;
   logic              trip;
   logic              hot;
   logic              hi_f;
   logic              lo_f;
   logic              fault;
   logic              mflt;
   logic              alert_n;
   logic [29:0]       pb;
   logic [15:0]       rd_data;
   logic              rd_strobe;
   logic [31:0]       seed = 32'h561B;
   int                bad_count = 0;
   int                cmp_count = 0;
   logic [15:0]       exp_q[$];  // expected reads
   logic [18:0][15:0] fmask = {16'h00FF, {5{16'hFFFF}}, {7{16'h001F}}, 16'h0007,
                               16'h0003, 16'h00FF, 16'h001F, 16'h00FF, 16'h00FF};
   regulator_setpoint_command_bank u_dut (.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda),
      .sda_out(), .sda_oe(sda_oe), .aux_sense_level(aux), .output_monitor_level(mon),
      .temperature(temp), .overtemp_trip(trip), .output_trim_offset(),
      .output_calibration_offset(), .load_line_code(), .load_line_set(),
      .good_window_high_code(), .good_window_low_code(), .current_limit_code(),
      .phase_balance_code(pb), .regulator_hot_indicator(hot), .aux_high_flag(hi_f),
      .aux_low_flag(lo_f), .aux_fault(fault), .monitor_fault(mflt), .alert_n(alert_n));
   bus_host h (.sda_oe(sda_oe), .scl(scl), .sda(sda), .rd_data(rd_data), .rd_strobe(rd_strobe));
   task automatic check(input logic [15:0] seen, input logic [15:0] ex);
      cmp_count++;
      if (seen !== ex) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, ex);
      end
   endtask
   task automatic results();
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic do_reset();
      nrst = 1'b0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // reads checked in order
   always @(posedge rd_strobe) check(rd_data, exp_q.pop_front());
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      results();
   end
   initial begin
      {nrst, aux, mon, temp, trip} = '0;
      do_reset();
      h.wr(8'hDD, 16'h0015, 1'b0);  // unmapped code
      for (int i = 0; i < 19; i++) begin
         exp_q.push_back(regulator_bank_pkg::REG_RST[i]);
         h.rd(regulator_bank_pkg::CMD_CODE[i], regulator_bank_pkg::REG_WIDE[i]);
         seed = xs(seed);
         h.wr(regulator_bank_pkg::CMD_CODE[i], seed[15:0] & fmask[i], regulator_bank_pkg::REG_WIDE[i]);
         exp_q.push_back(seed[15:0] & fmask[i]);
         h.rd(regulator_bank_pkg::CMD_CODE[i], regulator_bank_pkg::REG_WIDE[i]);
         if (i >= 7 && i <= 12) check(16'(pb[5*(i-7) +: 5]), seed[15:0] & fmask[i]);
      end
      do_reset();  // mid-run reset
      aux = 16'h0003;
      mon = 16'h0003;
      temp = 16'h0050;  // at release: still hot
      repeat (4) @(negedge clk);
      check(16'({hi_f, lo_f, fault, mflt, alert_n}), 16'h0016);
      h.wr(8'hF9, 16'h0002, 1'b0);  // mask the aux limits
      @(negedge clk);
      check(16'(alert_n), 16'h0001);
      trip = 1'b1;
      @(negedge clk);
      trip = 1'b0;
      repeat (4) @(negedge clk);
      check(16'(hot), 16'h0001);
      temp = 16'h004F;
      repeat (4) @(negedge clk);
      check(16'(hot), 16'h0000);
      results();
   end
endmodule
`default_nettype wire

// *** src/bit_sync.sv ***
`default_nettype none
// two-stage synchroniser for pin levels
module bit_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;   // first stage, read only by s2
      logic [WIDTH-1:0] s2;   // second stage
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // shift through both stages
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   // idle bus level is high, so reset to ones
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule
`default_nettype wire

// *** src/limit_check.sv ***
`default_nettype none
// registered limit comparators
module limit_check (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // limits in, results out
   monitor_if.check  mon
);
   typedef struct packed {
      logic aux_above;    // aux over high limit
      logic aux_below;    // aux under low limit
      logic aux_fault;    // aux over fault limit
      logic mon_fault;    // monitor over fault limit
      logic temp_below;   // temperature under release point
   } check_state_t;

   check_state_t st;
   check_state_t next_st;

   // unsigned compares of raw codes; one cycle of latency
   always_comb begin
      next_st            = st;
      next_st.aux_above  = mon.aux_level > mon.aux_high_limit;
      next_st.aux_below  = mon.aux_level < mon.aux_low_limit;
      next_st.aux_fault  = mon.aux_level > mon.aux_fault_limit;
      next_st.mon_fault  = mon.mon_level > mon.mon_fault_limit;
      next_st.temp_below = mon.temp_level < mon.hot_release;
   end

   // results clear under reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign mon.aux_above  = st.aux_above;
   assign mon.aux_below  = st.aux_below;
   assign mon.aux_fault  = st.aux_fault;
   assign mon.mon_fault  = st.mon_fault;
   assign mon.temp_below = st.temp_below;
endmodule
`default_nettype wire

// *** src/monitor_if.sv ***
`default_nettype none
// limits out, compare results back
interface monitor_if;
   logic [15:0] aux_level;        // aux sense measurement
   logic [15:0] mon_level;        // output monitor measurement
   logic [15:0] temp_level;       // measured temperature
   logic [15:0] aux_high_limit;   // aux high limit
   logic [15:0] aux_low_limit;    // aux low limit
   logic [15:0] aux_fault_limit;  // aux fault limit
   logic [15:0] mon_fault_limit;  // monitor fault limit
   logic [15:0] hot_release;      // hot release temperature
   logic        aux_above;        // aux over high limit
   logic        aux_below;        // aux under low limit
   logic        aux_fault;        // aux over fault limit
   logic        mon_fault;        // monitor over fault limit
   logic        temp_below;       // temperature under release

   modport bank (output aux_level, mon_level, temp_level, aux_high_limit,
                 aux_low_limit, aux_fault_limit, mon_fault_limit, hot_release,
                 input aux_above, aux_below, aux_fault, mon_fault, temp_below);
   modport check (input aux_level, mon_level, temp_level, aux_high_limit,
                  aux_low_limit, aux_fault_limit, mon_fault_limit, hot_release,
                  output aux_above, aux_below, aux_fault, mon_fault, temp_below);
endinterface
`default_nettype wire

// *** src/regulator_bank_pkg.sv ***
`default_nettype none
package regulator_bank_pkg;

   // register table size and index width
   localparam int NREG  = 19;
   localparam int IDX_W = 5;

   // command codes, entry 0 on the right
   localparam logic [NREG-1:0][7:0] CMD_CODE = {
      8'hF9, 8'hF5, 8'hF1, 8'hF0, 8'hEF, 8'hEE,
      8'hE8, 8'hE7, 8'hE6, 8'hE5, 8'hE4, 8'hE3,
      8'hE2, 8'hE1, 8'hE0, 8'hDF, 8'hDE, 8'hDC, 8'hDB};

   // reset values, same order
   localparam logic [NREG-1:0][15:0] REG_RST = {
      16'h0000, 16'h0002, 16'h0002, 16'h0000, 16'h0002, 16'h0050,
      16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010,
      16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0000};

   // two-byte commands (entries 13 to 17)
   localparam logic [NREG-1:0] REG_WIDE = 19'h3E000;

   // table entries
   localparam logic [IDX_W-1:0] IDX_TRIM       = 5'h00;
   localparam logic [IDX_W-1:0] IDX_CAL        = 5'h01;
   localparam logic [IDX_W-1:0] IDX_LL_CAL     = 5'h02;
   localparam logic [IDX_W-1:0] IDX_LL_SET     = 5'h03;
   localparam logic [IDX_W-1:0] IDX_GW_HIGH    = 5'h04;
   localparam logic [IDX_W-1:0] IDX_GW_LOW     = 5'h05;
   localparam logic [IDX_W-1:0] IDX_CUR_LIMIT  = 5'h06;
   localparam int               IDX_PHASE0     = 7;
   localparam logic [IDX_W-1:0] IDX_HOT_REL    = 5'h0D;
   localparam logic [IDX_W-1:0] IDX_AUX_HIGH   = 5'h0E;
   localparam logic [IDX_W-1:0] IDX_AUX_LOW    = 5'h0F;
   localparam logic [IDX_W-1:0] IDX_AUX_FAULT  = 5'h10;
   localparam logic [IDX_W-1:0] IDX_MON_FAULT  = 5'h11;
   localparam logic [IDX_W-1:0] IDX_ALERT_MASK = 5'h12;

   // field widths
   localparam int NPHASE  = 6;
   localparam int LL_W    = 5;
   localparam int GW_HI_W = 2;
   localparam int GW_LO_W = 3;
   localparam int CL_W    = 5;
   localparam int PB_W    = 5;

   // alert mask bit for aux limits
   localparam int MASK_AUX_BIT = 1;

   // serial framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] BIT_ONE   = 4'h1;
   localparam logic [1:0] BYTE_LOW  = 2'h0;
   localparam logic [1:0] BYTE_HIGH = 2'h1;
   localparam logic [1:0] BYTE_PAST = 2'h2;
   localparam logic [1:0] BYTE_STEP = 2'h1;

   // link sequencer states
   typedef enum logic [2:0] {
      LS_IDLE, LS_ADDR, LS_CMD, LS_WDATA, LS_ACK, LS_RDATA, LS_MACK, LS_SKIP
   } link_state_t;

   // command lookup: {hit, index}
   function automatic logic [IDX_W:0] find_cmd(input logic [7:0] code);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = 0; i < NREG; i++) begin
         if (CMD_CODE[i] == code) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction

endpackage
`default_nettype wire

// *** src/regulator_setpoint_command_bank.sv ***
// Function
// - trim and calibration offsets, byte, reset zero
// - five-bit load-line code, default 0x10
// - two-bit good-window high and clamp code
// - three-bit good-window low code, default 000
// - five-bit current-limit scale, default 0x10
// - six phase-balance gain codes, default 0x10
// - hot indicator drops below release temperature
// - aux sense high and low limits compared
// - aux and monitor fault limits flag faults
// - alert on aux limits unless masked
`default_nettype none
module regulator_setpoint_command_bank #(
   parameter logic [6:0] DEV_ADDR = 7'h40   // bus address, arbitrary default
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // two-wire management bus
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // measurements, already on clk
   input  wire logic [15:0] aux_sense_level,
   input  wire logic [15:0] output_monitor_level,
   input  wire logic [15:0] temperature,
   input  wire logic        overtemp_trip,
   // setpoints to the analog loops
   output logic [7:0]       output_trim_offset,
   output logic [7:0]       output_calibration_offset,
   output logic [4:0]       load_line_code,
   output logic [7:0]       load_line_set,
   output logic [1:0]       good_window_high_code,
   output logic [2:0]       good_window_low_code,
   output logic [4:0]       current_limit_code,
   output logic [29:0]      phase_balance_code,
   // status
   output logic             regulator_hot_indicator,
   output logic             aux_high_flag,
   output logic             aux_low_flag,
   output logic             aux_fault,
   output logic             monitor_fault,
   output logic             alert_n
);

   localparam int NREG  = regulator_bank_pkg::NREG;
   localparam int IDX_W = regulator_bank_pkg::IDX_W;

   // all bank state
   typedef struct packed {
      logic                          scl_q;      // previous synced clock
      logic                          sda_q;      // previous synced data
      regulator_bank_pkg::link_state_t state;    // sequencer state
      regulator_bank_pkg::link_state_t after;    // state after ack
      logic [3:0]                    bits;       // bits of current byte
      logic [7:0]                    shift;      // byte in or out
      logic                          rw;         // read bit of address
      logic [IDX_W-1:0]              idx;        // selected command entry
      logic [1:0]                    byte_no;    // byte within command
      logic [7:0]                    low_stage;  // low byte of wide write
      logic                          more;       // host acked a read byte
      logic                          sda_out;    // pulled-down level
      logic                          sda_oe;     // pulling the line
      logic [NREG-1:0][15:0]         regs;       // command storage
      logic                          hot;        // regulator hot
      logic                          aux_high;   // aux over high limit
      logic                          aux_low;    // aux under low limit
      logic                          aux_fault;  // aux fault
      logic                          mon_fault;  // monitor fault
      logic                          alert_n;    // alert, low active
   } bank_state_t;

   bank_state_t st;
   bank_state_t next_st;

   // synced pins
   logic scl_s;                 // bus clock on clk
   logic sda_s;                 // bus data on clk
   // edge and framing events
   logic scl_rise;              // clock rising
   logic scl_fall;              // clock falling
   logic frame_start;           // start or repeated start
   logic frame_stop;            // stop
   // command lookup and read data
   logic [IDX_W:0] lookup;      // {hit, index} of shifted byte
   logic [15:0]    rd_word;     // selected command value
   logic [7:0]     rd_byte;     // byte to send next
   logic           aux_alert;   // unmasked aux limit event

   // comparator link
   monitor_if mon_bus ();

   // pins cross into clk first
   bit_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({scl, sda_in}),
      .q    ({scl_s, sda_s})
   );

   // limits against measurements
   limit_check u_check (
      .clk  (clk),
      .nrst (nrst),
      .mon  (mon_bus.check)
   );

   // levels and limits to comparators
   assign mon_bus.aux_level       = aux_sense_level;
   assign mon_bus.mon_level       = output_monitor_level;
   assign mon_bus.temp_level      = temperature;
   assign mon_bus.aux_high_limit  = st.regs[regulator_bank_pkg::IDX_AUX_HIGH];
   assign mon_bus.aux_low_limit   = st.regs[regulator_bank_pkg::IDX_AUX_LOW];
   assign mon_bus.aux_fault_limit = st.regs[regulator_bank_pkg::IDX_AUX_FAULT];
   assign mon_bus.mon_fault_limit = st.regs[regulator_bank_pkg::IDX_MON_FAULT];
   assign mon_bus.hot_release     = st.regs[regulator_bank_pkg::IDX_HOT_REL];

   // edges from second sync stage only
   assign scl_rise    = scl_s & ~st.scl_q;
   assign scl_fall    = ~scl_s & st.scl_q;
   assign frame_start = scl_s & st.scl_q & st.sda_q & ~sda_s;
   assign frame_stop  = scl_s & st.scl_q & ~st.sda_q & sda_s;

   // command byte lookup
   assign lookup = regulator_bank_pkg::find_cmd(st.shift);

   // read byte: low, high if wide, else zero
   always_comb begin
      rd_word = st.regs[st.idx];
      if (st.byte_no == regulator_bank_pkg::BYTE_LOW) begin
         rd_byte = rd_word[7:0];
      end else if (st.byte_no == regulator_bank_pkg::BYTE_HIGH &&
                   regulator_bank_pkg::REG_WIDE[st.idx]) begin
         rd_byte = rd_word[15:8];
      end else begin
         rd_byte = 8'h00;
      end
   end

   // masked aux limit event
   assign aux_alert = (mon_bus.aux_above | mon_bus.aux_below) &
                      ~st.regs[regulator_bank_pkg::IDX_ALERT_MASK]
                              [regulator_bank_pkg::MASK_AUX_BIT];

   // sequencer, writes, status
   always_comb begin
      next_st       = st;
      next_st.scl_q = scl_s;
      next_st.sda_q = sda_s;

      if (frame_stop) begin
         // stop frees the line
         next_st.state  = regulator_bank_pkg::LS_IDLE;
         next_st.sda_oe = 1'b0;
      end else if (frame_start) begin
         // start: address byte next
         next_st.state  = regulator_bank_pkg::LS_ADDR;
         next_st.bits   = '0;
         next_st.sda_oe = 1'b0;
      end else begin
         case (st.state)
            regulator_bank_pkg::LS_ADDR,
            regulator_bank_pkg::LS_CMD,
            regulator_bank_pkg::LS_WDATA: begin
               if (scl_rise && st.bits != regulator_bank_pkg::BYTE_BITS) begin
                  // sample on rising clock, msb first
                  next_st.shift = {st.shift[6:0], sda_s};
                  next_st.bits  = 4'(st.bits + regulator_bank_pkg::BIT_ONE);
               end else if (scl_fall && st.bits == regulator_bank_pkg::BYTE_BITS) begin
                  // byte in: ack on falling clock
                  next_st.after = regulator_bank_pkg::LS_WDATA;
                  if (st.state == regulator_bank_pkg::LS_ADDR) begin
                     if (st.shift[7:1] == DEV_ADDR) begin
                        next_st.rw      = st.shift[0];
                        next_st.byte_no = regulator_bank_pkg::BYTE_LOW;
                        next_st.sda_oe  = 1'b1;
                        next_st.state   = regulator_bank_pkg::LS_ACK;
                        next_st.after   = st.shift[0] ? regulator_bank_pkg::LS_RDATA
                                                      : regulator_bank_pkg::LS_CMD;
                     end else begin
                        // not ours: stay off
                        next_st.state = regulator_bank_pkg::LS_SKIP;
                     end
                  end else if (st.state == regulator_bank_pkg::LS_CMD) begin
                     if (lookup[IDX_W]) begin
                        next_st.idx     = lookup[IDX_W-1:0];
                        next_st.byte_no = regulator_bank_pkg::BYTE_LOW;
                        next_st.sda_oe  = 1'b1;
                        next_st.state   = regulator_bank_pkg::LS_ACK;
                     end else begin
                        // unknown command: no ack
                        next_st.state = regulator_bank_pkg::LS_SKIP;
                     end
                  end else begin
                     // data; wide commands commit on high byte
                     next_st.sda_oe = 1'b1;
                     next_st.state  = regulator_bank_pkg::LS_ACK;
                     if (st.byte_no == regulator_bank_pkg::BYTE_LOW) begin
                        if (regulator_bank_pkg::REG_WIDE[st.idx]) begin
                           next_st.low_stage = st.shift;
                        end else begin
                           next_st.regs[st.idx] = {8'h00, st.shift};
                        end
                     end else if (st.byte_no == regulator_bank_pkg::BYTE_HIGH &&
                                  regulator_bank_pkg::REG_WIDE[st.idx]) begin
                        next_st.regs[st.idx] = {st.shift, st.low_stage};
                     end
                     // surplus bytes dropped
                     if (st.byte_no != regulator_bank_pkg::BYTE_PAST) begin
                        next_st.byte_no = 2'(st.byte_no + regulator_bank_pkg::BYTE_STEP);
                     end
                  end
               end
            end

            regulator_bank_pkg::LS_ACK: begin
               // ack over: release or send
               if (scl_fall) begin
                  next_st.bits  = '0;
                  next_st.state = st.after;
                  if (st.after == regulator_bank_pkg::LS_RDATA) begin
                     next_st.shift  = rd_byte;
                     next_st.sda_oe = ~rd_byte[7];
                  end else begin
                     next_st.sda_oe = 1'b0;
                  end
               end
            end

            regulator_bank_pkg::LS_RDATA: begin
               if (scl_rise) begin
                  // host has taken one bit
                  next_st.bits = 4'(st.bits + regulator_bank_pkg::BIT_ONE);
               end else if (scl_fall) begin
                  if (st.bits == regulator_bank_pkg::BYTE_BITS) begin
                     // release for the host's ack bit
                     next_st.sda_oe = 1'b0;
                     next_st.state  = regulator_bank_pkg::LS_MACK;
                  end else begin
                     next_st.shift  = {st.shift[6:0], 1'b0};
                     next_st.sda_oe = ~st.shift[6];
                  end
               end
            end

            regulator_bank_pkg::LS_MACK: begin
               if (scl_rise) begin
                  // low means the host wants another byte
                  next_st.more = ~sda_s;
                  if (!sda_s && st.byte_no != regulator_bank_pkg::BYTE_PAST) begin
                     next_st.byte_no = 2'(st.byte_no + regulator_bank_pkg::BYTE_STEP);
                  end
               end else if (scl_fall) begin
                  if (st.more) begin
                     next_st.bits   = '0;
                     next_st.shift  = rd_byte;
                     next_st.sda_oe = ~rd_byte[7];
                     next_st.state  = regulator_bank_pkg::LS_RDATA;
                  end else begin
                     next_st.state = regulator_bank_pkg::LS_SKIP;
                  end
               end
            end

            default: begin
               // idle or skip: wait for framing
               next_st.sda_oe = 1'b0;
            end
         endcase
      end

      // hot indicator: trip sets, release clears, set wins
      if (overtemp_trip) begin
         next_st.hot = 1'b1;
      end else if (mon_bus.temp_below) begin
         next_st.hot = 1'b0;
      end

      // flags follow comparators
      next_st.aux_high  = mon_bus.aux_above;
      next_st.aux_low   = mon_bus.aux_below;
      next_st.aux_fault = mon_bus.aux_fault;
      next_st.mon_fault = mon_bus.mon_fault;
      next_st.alert_n   = ~aux_alert;
   end

   // reset loads defaults
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st         <= '0;
         st.scl_q   <= 1'b1;
         st.sda_q   <= 1'b1;
         st.regs    <= regulator_bank_pkg::REG_RST;
         st.alert_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // pin drive: only ever pulls low
   assign sda_out = st.sda_out;
   assign sda_oe  = st.sda_oe;

   // setpoints from storage
   assign output_trim_offset        = st.regs[regulator_bank_pkg::IDX_TRIM][7:0];
   assign output_calibration_offset = st.regs[regulator_bank_pkg::IDX_CAL][7:0];
   assign load_line_code            =
      st.regs[regulator_bank_pkg::IDX_LL_CAL][regulator_bank_pkg::LL_W-1:0];
   assign load_line_set             = st.regs[regulator_bank_pkg::IDX_LL_SET][7:0];
   assign good_window_high_code     =
      st.regs[regulator_bank_pkg::IDX_GW_HIGH][regulator_bank_pkg::GW_HI_W-1:0];
   assign good_window_low_code      =
      st.regs[regulator_bank_pkg::IDX_GW_LOW][regulator_bank_pkg::GW_LO_W-1:0];
   assign current_limit_code        =
      st.regs[regulator_bank_pkg::IDX_CUR_LIMIT][regulator_bank_pkg::CL_W-1:0];

   // one gain code per phase
   generate
      for (genvar p = 0; p < regulator_bank_pkg::NPHASE; p++) begin : g_phase
         assign phase_balance_code[p*regulator_bank_pkg::PB_W +: regulator_bank_pkg::PB_W] =
            st.regs[regulator_bank_pkg::IDX_PHASE0 + p][regulator_bank_pkg::PB_W-1:0];
      end
   endgenerate

   // status outputs
   assign regulator_hot_indicator = st.hot;
   assign aux_high_flag           = st.aux_high;
   assign aux_low_flag            = st.aux_low;
   assign aux_fault               = st.aux_fault;
   assign monitor_fault           = st.mon_fault;
   assign alert_n                 = st.alert_n;
endmodule
`default_nettype wire
